// file: hdl/acis_chan_decode.sv
// Channel code decoder: positive input, negative input and gain
`timescale 1ns/10ps
`default_nettype none
module acis_chan_decode (
   input  wire logic [4:0] code,     // Channel and gain code
   output logic      [3:0] pos_in,   // Positive or single-ended input
   output logic      [3:0] neg_in,   // Negative input, none when single-ended
   output logic      [1:0] gain      // Gain encoding
);
   // Table walk of the code space
   always_comb begin
      pos_in = acis_pkg::IN_NONE;
      neg_in = acis_pkg::IN_NONE;
      gain   = acis_pkg::ACIS_GAIN_NONE;
      if (code <= acis_pkg::CH_SINGLE_LAST) begin
         pos_in = {1'b0, code[2:0]};
      end else if (code <= acis_pkg::CH_GAIN_LAST) begin
         pos_in = {2'h0, code[2], code[0]};
         neg_in = {2'h0, code[2], 1'b0};
         gain   = code[1] ? acis_pkg::ACIS_GAIN_200X : acis_pkg::ACIS_GAIN_10X;
      end else if (code <= acis_pkg::CH_NEG1_LAST) begin
         pos_in = {1'b0, code[2:0]};
         neg_in = 4'h1;
         gain   = acis_pkg::ACIS_GAIN_1X;
      end else if (code <= acis_pkg::CH_NEG2_LAST) begin
         pos_in = {1'b0, code[2:0]};
         neg_in = 4'h2;
         gain   = acis_pkg::ACIS_GAIN_1X;
      end else if (code == acis_pkg::CH_BANDGAP) begin
         pos_in = acis_pkg::IN_BANDGAP;
      end else begin
         pos_in = acis_pkg::IN_GROUND;
      end
   end
endmodule : acis_chan_decode
`default_nettype wire

// file: hdl/acis_pkg.sv
// Package: register map, field layout and decode constants for the input select block
package acis_pkg;
   // Register map (byte addresses)
   localparam logic [7:0] CONVERTER_INPUT_SELECT_ADDR = 8'h7c;
   localparam logic [7:0] RESULT_LOW_BYTE_ADDR        = 8'h78;
   localparam logic [7:0] RESULT_HIGH_BYTE_ADDR       = 8'h79;
   localparam logic [7:0] SELECT_RESET                = 8'h00;
   // Field layout of the selection register
   localparam int REF_MSB   = 7;
   localparam int REF_LSB   = 6;
   localparam int ALIGN_BIT = 5;
   localparam int CHAN_MSB  = 4;
   localparam int CHAN_LSB  = 0;
   // Reference choices
   typedef enum logic [1:0] {
      ACIS_REF_PIN    = 2'h0,
      ACIS_REF_SUPPLY = 2'h1,
      ACIS_REF_1V1    = 2'h2,
      ACIS_REF_2V56   = 2'h3
   } acis_ref_e;
   // Channel code boundaries
   localparam logic [4:0] CH_SINGLE_LAST = 5'h07;
   localparam logic [4:0] CH_GAIN_LAST   = 5'h0f;
   localparam logic [4:0] CH_NEG1_LAST   = 5'h17;
   localparam logic [4:0] CH_NEG2_LAST   = 5'h1d;
   localparam logic [4:0] CH_BANDGAP     = 5'h1e;
   localparam logic [4:0] CH_GROUND      = 5'h1f;
   // Gain encodings
   typedef enum logic [1:0] {
      ACIS_GAIN_NONE = 2'h0,
      ACIS_GAIN_1X   = 2'h1,
      ACIS_GAIN_10X  = 2'h2,
      ACIS_GAIN_200X = 2'h3
   } acis_gain_e;
   // Input selector encodings (0..7 are analog inputs)
   localparam logic [3:0] IN_BANDGAP = 4'h8;
   localparam logic [3:0] IN_GROUND  = 4'h9;
   localparam logic [3:0] IN_NONE    = 4'hf;
   localparam int RESULT_W = 10;
endpackage : acis_pkg

// file: hdl/acis_top.sv
// Converter input select register with deferred reference/channel and result view
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
//-----------------------------------------------------------------------
// Function
// - Two-bit reference field picks pin, supply, 1.1V or 2.56V reference.
// - Reference change mid-conversion applies only once the done flag sets.
// - Bit 5 set gives left-aligned result, clear gives right-aligned.
// - Alignment change affects result view at once, even mid-conversion.
// - Bits 4:0 pick analog inputs and differential gain.
// - Channel change mid-conversion applies only once the done flag sets.
// - Codes 0-7 single inputs; 11110 bandgap; 11111 ground.
// - Differential codes decode to documented pairs and gains.
// - Done flag sets when conversion ends and result stored.
// - After low byte read, result frozen until high byte read.
//-----------------------------------------------------------------------
module acis_top (
   input  wire logic       clk,             // System clock, 125 MHz
   input  wire logic       rstn,            // Synchronous reset, active low
   input  wire logic [7:0] addr,            // Register byte address
   input  wire logic [7:0] wdata,           // Write data
   input  wire logic       wr,              // Write strobe
   input  wire logic       rd,              // Read strobe
   output logic      [7:0] rdata,           // Read data, cycle after rd
   input  wire logic       conv_start,      // Converter core starts a conversion
   input  wire logic       conv_end,        // Converter core finished, result valid
   input  wire logic [9:0] conv_result,     // Raw result from the core
   output logic      [1:0] reference_choice,// Active reference
   output logic      [3:0] pos_input,       // Active positive input
   output logic      [3:0] neg_input,       // Active negative input
   output logic      [1:0] gain_select,     // Active gain
   output logic            conversion_done_flag, // Pulse: result stored
   output logic            busy             // Conversion in progress
);
   //--------------------------------------------------------------------
   // Registers
   //--------------------------------------------------------------------
   logic [7:0]                     converter_input_select;
   logic [1:0]                     active_ref;
   logic [4:0]                     active_chan;
   logic [acis_pkg::RESULT_W-1:0]  result;
   logic                           result_locked;
   logic                           pending_store;
   logic [acis_pkg::RESULT_W-1:0]  pending_val;
   logic [3:0]                     dec_pos;
   logic [3:0]                     dec_neg;
   logic [1:0]                     dec_gain;
   logic [7:0]                     next_rdata;
   logic                           wr_sel;
   logic                           rd_low;
   logic                           rd_high;
   logic                           store_now;
   logic [acis_pkg::RESULT_W-1:0]  store_val;

   assign wr_sel  = wr && (addr == acis_pkg::CONVERTER_INPUT_SELECT_ADDR);
   assign rd_low  = rd && (addr == acis_pkg::RESULT_LOW_BYTE_ADDR);
   assign rd_high = rd && (addr == acis_pkg::RESULT_HIGH_BYTE_ADDR);

   // Software-visible selection register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         converter_input_select <= acis_pkg::SELECT_RESET;
      end else if (wr_sel) begin
         converter_input_select <= wdata;
      end
   end

   // Conversion in progress tracking
   always_ff @(posedge clk) begin
      if (!rstn) begin
         busy <= 1'b0;
      end else if (conv_start) begin
         busy <= 1'b1;
      end else if (conv_end) begin
         busy <= 1'b0;
      end
   end

   // Active reference/channel: follow register when idle, hold while busy or while
   // a finished result waits behind the read lock, so the switch meets the done flag
   always_ff @(posedge clk) begin
      if (!rstn) begin
         active_ref  <= acis_pkg::SELECT_RESET[acis_pkg::REF_MSB:acis_pkg::REF_LSB];
         active_chan <= acis_pkg::SELECT_RESET[acis_pkg::CHAN_MSB:acis_pkg::CHAN_LSB];
      end else if ((!busy && !pending_store) || store_now) begin
         active_ref  <= converter_input_select[acis_pkg::REF_MSB:acis_pkg::REF_LSB];
         active_chan <= converter_input_select[acis_pkg::CHAN_MSB:acis_pkg::CHAN_LSB];
      end
   end

   // Channel decode
   acis_chan_decode u_dec (
      .code   (active_chan),
      .pos_in (dec_pos),
      .neg_in (dec_neg),
      .gain   (dec_gain)
   );

   // Registered analog controls
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reference_choice <= acis_pkg::ACIS_REF_PIN;
         pos_input        <= 4'h0;
         neg_input        <= acis_pkg::IN_NONE;
         gain_select      <= acis_pkg::ACIS_GAIN_NONE;
      end else begin
         reference_choice <= active_ref;
         pos_input        <= dec_pos;
         neg_input        <= dec_neg;
         gain_select      <= dec_gain;
      end
   end

   // Result update blocked between low-byte and high-byte reads
   assign store_now = (conv_end || pending_store) && !result_locked;
   assign store_val = conv_end ? conv_result : pending_val;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         result_locked <= 1'b0;
      end else if (rd_high) begin
         result_locked <= 1'b0;
      end else if (rd_low) begin
         result_locked <= 1'b1;
      end
   end

   // Hold a result that finished while the view was locked
   always_ff @(posedge clk) begin
      if (!rstn) begin
         pending_store <= 1'b0;
         pending_val   <= '0;
      end else if (conv_end && result_locked) begin
         pending_store <= 1'b1;
         pending_val   <= conv_result;
      end else if (store_now) begin
         pending_store <= 1'b0;
      end
   end

   // Result store and completion flag
   always_ff @(posedge clk) begin
      if (!rstn) begin
         result               <= '0;
         conversion_done_flag <= 1'b0;
      end else begin
         conversion_done_flag <= store_now;
         if (store_now) begin
            result <= store_val;
         end
      end
   end

   // Read mux: alignment applied live to the stored result
   always_comb begin
      next_rdata = 8'h00;
      if (rd) begin
         case (addr)
            acis_pkg::CONVERTER_INPUT_SELECT_ADDR: next_rdata = converter_input_select;
            acis_pkg::RESULT_LOW_BYTE_ADDR: begin
               if (converter_input_select[acis_pkg::ALIGN_BIT]) begin
                  next_rdata = {result[1:0], 6'h00};
               end else begin
                  next_rdata = result[7:0];
               end
            end
            acis_pkg::RESULT_HIGH_BYTE_ADDR: begin
               if (converter_input_select[acis_pkg::ALIGN_BIT]) begin
                  next_rdata = result[9:2];
               end else begin
                  next_rdata = {6'h00, result[9:8]};
               end
            end
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= next_rdata;
      end
   end

   //--------------------------------------------------------------------
   // Assertions
   //--------------------------------------------------------------------
   a_ref_hold_busy: assert property (@(posedge clk) disable iff (!rstn)
      (busy && !store_now) |=> $stable(active_ref))
      else $error("reference changed during conversion");
   a_chan_hold_busy: assert property (@(posedge clk) disable iff (!rstn)
      (busy && !store_now) |=> $stable(active_chan))
      else $error("channel changed during conversion");
   a_sel_hold_pending: assert property (@(posedge clk) disable iff (!rstn)
      (pending_store && !store_now) |=> $stable(active_chan) && $stable(active_ref))
      else $error("selection changed while result pending");
   a_ref_follow_idle: assert property (@(posedge clk) disable iff (!rstn)
      (!busy && !pending_store) |=> ##1 (reference_choice ==
         $past(converter_input_select[acis_pkg::REF_MSB:acis_pkg::REF_LSB], 2)))
      else $error("reference not applied when idle");
   a_done_on_store: assert property (@(posedge clk) disable iff (!rstn)
      store_now |=> conversion_done_flag && (result == $past(store_val)))
      else $error("done flag or result missing");
   a_lock_blocks: assert property (@(posedge clk) disable iff (!rstn)
      (result_locked && !rd_high) |=> $stable(result))
      else $error("result updated while locked");
   a_left_high: assert property (@(posedge clk) disable iff (!rstn)
      (rd_high && converter_input_select[acis_pkg::ALIGN_BIT]) |=> rdata == $past(result[9:2]))
      else $error("left aligned high byte wrong");
   a_right_low: assert property (@(posedge clk) disable iff (!rstn)
      (rd_low && !converter_input_select[acis_pkg::ALIGN_BIT]) |=> rdata == $past(result[7:0]))
      else $error("right aligned low byte wrong");
   a_reset_zero: assert property (@(posedge clk)
      !rstn |=> converter_input_select == 8'h00)
      else $error("select register not zero after reset");
   a_ground_code: assert property (@(posedge clk) disable iff (!rstn)
      (active_chan == acis_pkg::CH_GROUND) |=> pos_input == acis_pkg::IN_GROUND)
      else $error("ground code decode wrong");
   a_gain_200: assert property (@(posedge clk) disable iff (!rstn)
      (active_chan == 5'h0b) |=> gain_select == acis_pkg::ACIS_GAIN_200X && neg_input == 4'h0)
      else $error("200x decode wrong");
endmodule : acis_top
`default_nettype wire

// file: test/acis_top_tb.sv
// Self-checking testbench for the converter input select block
`timescale 1ns/10ps
`default_nettype none
module acis_top_tb;
   logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, rd_q = 1'b0;
   logic       conv_start = 1'b0, conv_end = 1'b0, conversion_done_flag, busy;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, sel, exp_q[$];
   logic [9:0] conv_result = 10'h000, res, res2, res3;
   logic [3:0] pos_input, neg_input, ep, en;
   logic [1:0] reference_choice, gain_select, eg;
   integer     seed = 32'h6a36, lo;
   int         n_errors = 0, n_compared = 0, cycles = 0;

   acis_top dut_u (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .conv_start(conv_start), .conv_end(conv_end),
      .conv_result(conv_result), .reference_choice(reference_choice),
      .pos_input(pos_input), .neg_input(neg_input), .gain_select(gain_select),
      .conversion_done_flag(conversion_done_flag), .busy(busy));

   // Clock, 8 ns period
   always #4 clk = ~clk;

   // Cycle ceiling against hangs
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // Read data watcher: oldest noted value against rdata in the cycle after rd
   always @(posedge clk) begin
      if (rd_q) check({2'b00, rdata}, {2'b00, exp_q.pop_front()});
      rd_q <= rd;
   end

   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("compared %0d, mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : report_and_stop

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(e);
      @(posedge clk);
      rd   <= 1'b0;
   endtask : rd_chk

   // Converter core pulses; the result bus is scrambled outside its valid cycle
   task automatic conv(input logic st, input logic [9:0] r);
      @(posedge clk);
      conv_start  <= st;
      conv_end    <= ~st;
      conv_result <= r;
      @(posedge clk);
      conv_start  <= 1'b0;
      conv_end    <= 1'b0;
      conv_result <= ~r;
   endtask : conv

   // Expected input pair and gain of a channel code
   task automatic dec(input logic [4:0] c);
      ep = {1'b0, c[2:0]};
      en = 4'hf;
      eg = 2'h0;
      if (c >= 5'h08 && c <= 5'h0f) begin
         ep = {2'b00, c[2], c[0]};
         en = {2'b00, c[2], 1'b0};
         eg = {1'b1, c[1]};
      end else if (c >= 5'h10 && c <= 5'h1d) begin
         en = c[3] ? 4'h2 : 4'h1;
         eg = 2'h1;
      end else if (c >= 5'h1e) begin
         ep = {3'b100, c[0]};
      end
   endtask : dec

   task automatic chk_sel(input logic [7:0] s);
      dec(s[4:0]);
      check(10'(reference_choice), 10'(s[7:6]));
      check(10'(pos_input), 10'(ep));
      check(10'(neg_input), 10'(en));
      check(10'(gain_select), 10'(eg));
   endtask : chk_sel

   initial begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      @(posedge clk);
      #1;
      chk_sel(8'h00);
      rd_chk(8'h7c, 8'h00);
      rd_chk(8'h7d, 8'h00);
      $display("test reset done");
      // Every channel code and reference, random alignment; 2.56V reference forced on codes 8-29 with bit 1 set
      for (int i = 0; i < 32; i++) begin
         lo  = $random(seed);
         sel = {i[1:0], lo[0], i[4:0]};
         if (i >= 8 && i <= 29 && i[1]) sel[7:6] = 2'h3;
         wr_reg(8'h7c, sel);
         repeat (3) @(posedge clk);
         #1;
         chk_sel(sel);
         rd_chk(8'h7c, sel);
      end
      $display("test decode done");
      // Reference and channel change held until the conversion ends
      wr_reg(8'h7c, 8'h00);
      res = 10'($random(seed));
      conv(1'b1, 10'h000);
      wr_reg(8'h7c, 8'hcd);
      repeat (4) @(posedge clk);
      #1;
      chk_sel(8'h00);
      check(10'(busy), 10'h001);
      conv(1'b0, res);
      #1;
      check(10'(conversion_done_flag), 10'h001);
      @(posedge clk);
      #1;
      check(10'(conversion_done_flag), 10'h000);
      repeat (2) @(posedge clk);
      #1;
      chk_sel(8'hcd);
      $display("test deferred done");
      // Alignment, also switched in mid-conversion
      rd_chk(8'h78, res[7:0]);
      rd_chk(8'h79, {6'h00, res[9:8]});
      conv(1'b1, 10'h000);
      wr_reg(8'h7c, 8'hed);
      rd_chk(8'h78, {res[1:0], 6'h00});
      rd_chk(8'h79, res[9:2]);
      res2 = 10'($random(seed));
      conv(1'b0, res2);
      $display("test align done");
      // Low read locks the result until the high byte is read
      rd_chk(8'h78, {res2[1:0], 6'h00});
      res3 = 10'($random(seed));
      conv(1'b1, 10'h000);
      conv(1'b0, res3);
      // New selection while the finished result waits behind the lock
      wr_reg(8'h7c, 8'h7e);
      repeat (3) @(posedge clk);
      #1;
      chk_sel(8'hed);
      check(10'(conversion_done_flag), 10'h000);
      rd_chk(8'h79, res2[9:2]);
      @(posedge clk);
      #1;
      check(10'(conversion_done_flag), 10'h001);
      wr_reg(8'h78, 8'hff);
      #1;
      chk_sel(8'h7e);
      rd_chk(8'h79, res3[9:2]);
      repeat (3) @(posedge clk);
      $display("test lock done");
      report_and_stop();
   end
endmodule : acis_top_tb
`default_nettype wire
